// file: verilog/hvw_regs.svh
// Register offsets, field positions and timing constants of the wake block
`ifndef HVW_REGS_SVH
`define HVW_REGS_SVH
`define HVW_ADDR_W 4
`define HVW_OFF_CTRL 4'h0
`define HVW_OFF_PULL 4'h1
`define HVW_OFF_EVT 4'h2
`define HVW_OFF_ALT 4'h3
`define HVW_OFF_LVL 4'h4
`define HVW_OFF_MASK 4'h5
`define HVW_OFF_MODE 4'h6
`define HVW_CTRL_EN 0
`define HVW_CTRL_CYC 1
`define HVW_CTRL_ALT_EN 2
`define HVW_LVL_MAIN 0
`define HVW_LVL_ALT 1
`define HVW_EVT_BIT 0
`define HVW_PULL_NONE 2'h0
`define HVW_PULL_DOWN 2'h1
`define HVW_PULL_UP 2'h2
`define HVW_PULL_AUTO 2'h3
`define HVW_FILT_NS 16000
`define HVW_CLK_PERIOD_NS 8
`define HVW_FILT_CYC (`HVW_FILT_NS / `HVW_CLK_PERIOD_NS)
`define HVW_CNT_W 11
`endif

// file: verilog/hvw_pkg.sv
// Types shared by the wake block modules
package hvw_pkg;
    typedef enum logic [1:0] {
        HVW_PM_NORMAL,
        HVW_PM_STOP,
        HVW_PM_SLEEP,
        HVW_PM_FAILSAFE
    } hvw_pmode_t;
    typedef enum logic [1:0] {
        HVW_F_IDLE,
        HVW_F_RUN
    } hvw_fstate_t;
endpackage : hvw_pkg

// file: verilog/hvw_sync.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/10ps
module hvw_sync (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic pin_sync
);
    import hvw_pkg::*;
    typedef struct packed {
        logic meta;
        logic sync;
    } hvw_sync_st_t;
    hvw_sync_st_t st_ff;
    hvw_sync_st_t nxt_st;

    always_comb begin
        nxt_st.meta = pin_in;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_sync = st_ff.sync;
endmodule : hvw_sync

// file: verilog/hvw_filter.sv
// Deglitch filter: accepts a new level only after it held for the filter time
`timescale 1ns/10ps
`include "hvw_regs.svh"
module hvw_filter (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic level_in,
    output logic level_out,
    output logic edge_pulse
);
    import hvw_pkg::*;
    localparam logic [`HVW_CNT_W-1:0] FILT_LAST =
        `HVW_CNT_W'(`HVW_FILT_CYC - 1);
    typedef struct packed {
        hvw_fstate_t fsm;
        logic [`HVW_CNT_W-1:0] cnt;
        logic level;
        logic evt;
    } hvw_filt_st_t;
    hvw_filt_st_t st_ff;
    hvw_filt_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.evt = 1'b0;
        case (st_ff.fsm)
            HVW_F_IDLE: begin
                if (level_in != st_ff.level) begin
                    nxt_st.fsm = HVW_F_RUN;
                    nxt_st.cnt = '0;
                end
            end
            HVW_F_RUN: begin
                if (level_in == st_ff.level) begin
                    // Crossed back inside the window: pulse dropped
                    nxt_st.fsm = HVW_F_IDLE;
                end else if (st_ff.cnt == FILT_LAST) begin
                    nxt_st.level = level_in;
                    nxt_st.evt = 1'b1;
                    nxt_st.fsm = HVW_F_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt + `HVW_CNT_W'(1);
                end
            end
            default: begin
                nxt_st.fsm = HVW_F_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level_out = st_ff.level;
    assign edge_pulse = st_ff.evt;
endmodule : hvw_filter

// file: verilog/hvw_wake.sv
// High-voltage wake input detector with register port and interrupt
//
// Overview of operation
// - Both rising and falling crossings of the wake pin count as events.
// - Events interrupt in normal/stop mode and wake the device otherwise.
// - Software picks static sense (always on) or cyclic sense (windowed).
// - Static sense passes the pin through a 16 us deglitch filter.
// - A crossing starts the filter and a crossing back discards it.
// - A control bit written by software enables the pin's wake function.
// - Each accepted wake sets a status flag readable in every mode.
// - The live pin level is readable in normal, stop and init modes.
// - In cyclic sense the level register holds the last sampled level.
// - The multipurpose pin as wake input is filtered and has own status.
// - A two-bit pull select picks none, down, up or automatic bias.
// - Cyclic sense samples once as each on-window closes; a changed sample wakes.
`timescale 1ns/10ps
`include "hvw_regs.svh"
module hvw_wake (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hv_wake_pin,
    input wire logic fail_out_multipurpose_pin,
    input wire logic cyclic_on_window,
    input wire hvw_pkg::hvw_pmode_t power_mode,
    input wire logic init_mode,
    input wire logic [`HVW_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    output logic wake_request,
    output logic pull_up_en,
    output logic pull_down_en
);
    import hvw_pkg::*;
    typedef struct packed {
        logic wake_en;
        logic cyclic;
        logic alt_en;
        logic [1:0] pull_sel;
        logic evt_flag;
        logic alt_flag;
        logic [1:0] mask;
        logic lvl_main;
        logic lvl_alt;
        logic samp_valid;
        logic in_window_d;
        logic [7:0] rdata;
        logic irq;
        logic wake_req;
        logic pu;
        logic pd;
    } hvw_st_t;
    hvw_st_t st_ff;
    hvw_st_t nxt_st;

    logic main_sync;
    logic alt_sync;
    logic main_filt;
    logic main_edge;
    logic alt_filt;
    logic alt_edge;
    logic cyc_sync;

    hvw_sync u_sync_main (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(hv_wake_pin),
        .pin_sync(main_sync)
    );
    hvw_sync u_sync_alt (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(fail_out_multipurpose_pin),
        .pin_sync(alt_sync)
    );
    hvw_sync u_sync_win (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in(cyclic_on_window),
        .pin_sync(cyc_sync)
    );
    hvw_filter u_filt_main (
        .clock(clock),
        .sys_rst(sys_rst),
        .level_in(main_sync),
        .level_out(main_filt),
        .edge_pulse(main_edge)
    );
    hvw_filter u_filt_alt (
        .clock(clock),
        .sys_rst(sys_rst),
        .level_in(alt_sync),
        .level_out(alt_filt),
        .edge_pulse(alt_edge)
    );

    logic main_evt;
    logic alt_evt;
    logic cyc_samp;
    logic cyc_evt;
    logic lvl_vis;
    logic active_mode;
    logic wr_ctrl;
    logic wr_pull;
    logic wr_evt;
    logic wr_alt;
    logic wr_mask;
    logic [1:0] flags_new;

    always_comb begin
        nxt_st = st_ff;
        active_mode = (power_mode == HVW_PM_NORMAL) ||
            (power_mode == HVW_PM_STOP);
        lvl_vis = active_mode || init_mode;
        wr_ctrl = reg_wr && (reg_addr == `HVW_OFF_CTRL);
        wr_pull = reg_wr && (reg_addr == `HVW_OFF_PULL);
        wr_evt = reg_wr && (reg_addr == `HVW_OFF_EVT);
        wr_alt = reg_wr && (reg_addr == `HVW_OFF_ALT);
        wr_mask = reg_wr && (reg_addr == `HVW_OFF_MASK);

        // Cyclic sampling at the end of each on-window
        nxt_st.in_window_d = cyc_sync;
        cyc_samp = st_ff.in_window_d && !cyc_sync;
        cyc_evt = cyc_samp && st_ff.samp_valid &&
            (main_sync != st_ff.lvl_main);
        // First sample after entering cyclic only seeds the reference
        if (!st_ff.cyclic) begin
            nxt_st.samp_valid = 1'b0;
        end else if (cyc_samp) begin
            nxt_st.samp_valid = 1'b1;
        end

        main_evt = st_ff.wake_en &&
            (st_ff.cyclic ? cyc_evt : main_edge);
        alt_evt = st_ff.alt_en && alt_edge;

        // Set beats a clear arriving in the same cycle
        if (wr_evt && reg_wdata[`HVW_EVT_BIT]) begin
            nxt_st.evt_flag = 1'b0;
        end
        if (main_evt) begin
            nxt_st.evt_flag = 1'b1;
        end
        if (wr_alt && reg_wdata[`HVW_EVT_BIT]) begin
            nxt_st.alt_flag = 1'b0;
        end
        if (alt_evt) begin
            nxt_st.alt_flag = 1'b1;
        end

        if (wr_ctrl) begin
            nxt_st.wake_en = reg_wdata[`HVW_CTRL_EN];
            nxt_st.cyclic = reg_wdata[`HVW_CTRL_CYC];
            nxt_st.alt_en = reg_wdata[`HVW_CTRL_ALT_EN];
        end
        if (wr_pull) begin
            nxt_st.pull_sel = reg_wdata[1:0];
        end
        if (wr_mask) begin
            nxt_st.mask = reg_wdata[1:0];
        end

        // Level tracking: live in static, last sample in cyclic
        if (st_ff.cyclic) begin
            if (cyc_samp) begin
                nxt_st.lvl_main = main_sync;
            end
        end else begin
            nxt_st.lvl_main = main_filt;
        end
        nxt_st.lvl_alt = alt_filt;

        case (st_ff.pull_sel)
            `HVW_PULL_DOWN: begin
                nxt_st.pu = 1'b0;
                nxt_st.pd = 1'b1;
            end
            `HVW_PULL_UP: begin
                nxt_st.pu = 1'b1;
                nxt_st.pd = 1'b0;
            end
            `HVW_PULL_AUTO: begin
                // Bias follows the seen level to hold it
                nxt_st.pu = main_sync;
                nxt_st.pd = !main_sync;
            end
            default: begin
                nxt_st.pu = 1'b0;
                nxt_st.pd = 1'b0;
            end
        endcase

        flags_new = {alt_evt, main_evt};
        nxt_st.irq = |({nxt_st.alt_flag, nxt_st.evt_flag} & ~nxt_st.mask) &&
            active_mode;
        // Wake request is a one-cycle pulse per cycle with an accepted event; main and alt events in one cycle give one pulse
        nxt_st.wake_req = (|flags_new) && !active_mode;

        nxt_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `HVW_OFF_CTRL: begin
                    nxt_st.rdata[`HVW_CTRL_EN] = st_ff.wake_en;
                    nxt_st.rdata[`HVW_CTRL_CYC] = st_ff.cyclic;
                    nxt_st.rdata[`HVW_CTRL_ALT_EN] = st_ff.alt_en;
                end
                `HVW_OFF_PULL: begin
                    nxt_st.rdata[1:0] = st_ff.pull_sel;
                end
                `HVW_OFF_EVT: begin
                    nxt_st.rdata[`HVW_EVT_BIT] = st_ff.evt_flag;
                end
                `HVW_OFF_ALT: begin
                    nxt_st.rdata[`HVW_EVT_BIT] = st_ff.alt_flag;
                end
                `HVW_OFF_LVL: begin
                    nxt_st.rdata[`HVW_LVL_MAIN] = st_ff.lvl_main && lvl_vis;
                    nxt_st.rdata[`HVW_LVL_ALT] = st_ff.lvl_alt && lvl_vis;
                end
                `HVW_OFF_MASK: begin
                    nxt_st.rdata[1:0] = st_ff.mask;
                end
                `HVW_OFF_MODE: begin
                    nxt_st.rdata[1:0] = power_mode;
                    nxt_st.rdata[2] = init_mode;
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign irq = st_ff.irq;
    assign wake_request = st_ff.wake_req;
    assign pull_up_en = st_ff.pu;
    assign pull_down_en = st_ff.pd;
endmodule : hvw_wake

// file: tb/hvw_wake_monitor.sv
// Port-level checks of the wake block
`timescale 1ns/10ps
`include "hvw_regs.svh"
module hvw_wake_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hv_wake_pin,
    input wire logic fail_out_multipurpose_pin,
    input wire logic cyclic_on_window,
    input wire hvw_pkg::hvw_pmode_t power_mode,
    input wire logic [`HVW_ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic irq,
    input wire logic wake_request,
    input wire logic pull_up_en,
    input wire logic pull_down_en
);
    import hvw_pkg::*;
    logic pin_ff;
    logic [10:0] cnt_ff;
    logic [10:0] nxt_cnt;
    logic alt_ff;
    logic [10:0] alt_cnt_ff;
    logic [10:0] nxt_alt_cnt;
    logic [3:0] win_cnt_ff;
    logic [3:0] nxt_win_cnt;
    // Cycles the pin has rested, saturating
    always_comb begin
        nxt_cnt = cnt_ff;
        if (hv_wake_pin != pin_ff) begin
            nxt_cnt = 11'h000;
        end else if (cnt_ff != 11'h7ff) begin
            nxt_cnt = cnt_ff + 11'h001;
        end
        nxt_alt_cnt = alt_cnt_ff;
        if (fail_out_multipurpose_pin != alt_ff) begin
            nxt_alt_cnt = 11'h000;
        end else if (alt_cnt_ff != 11'h7ff) begin
            nxt_alt_cnt = alt_cnt_ff + 11'h001;
        end
        // Cycles since the sense window closed
        nxt_win_cnt = win_cnt_ff;
        if (cyclic_on_window) begin
            nxt_win_cnt = 4'h0;
        end else if (win_cnt_ff != 4'hf) begin
            nxt_win_cnt = win_cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pin_ff <= 1'b0;
            cnt_ff <= 11'h000;
            alt_ff <= 1'b0;
            alt_cnt_ff <= 11'h000;
            win_cnt_ff <= 4'hf;
        end else begin
            pin_ff <= hv_wake_pin;
            cnt_ff <= nxt_cnt;
            alt_ff <= fail_out_multipurpose_pin;
            alt_cnt_ff <= nxt_alt_cnt;
            win_cnt_ff <= nxt_win_cnt;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_hole;
        reg_rd && reg_addr > 4'h6;
    endsequence
    property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data off");
    property p_hole; s_hole |=> reg_rdata == 8'h00; endproperty
    a_hole: assert property (p_hole) else $error("unmapped data");
    property p_irq; irq |-> !$past(power_mode[1]); endproperty
    a_irq: assert property (p_irq) else $error("irq in sleep");
    property p_wmode; wake_request |-> $past(power_mode[1]); endproperty
    a_wmode: assert property (p_wmode) else $error("wake in run");
    property p_pulse; wake_request |=> !wake_request; endproperty
    a_pulse: assert property (p_pulse) else $error("wake too long");
    // Slack of a few cycles covers the synchroniser
    // Cyclic samples bypass the filter and follow a window close
    property p_filt;
        wake_request |-> cnt_ff > 11'h7ce || alt_cnt_ff > 11'h7ce ||
            win_cnt_ff < 4'h8;
    endproperty
    a_filt: assert property (p_filt) else $error("wake unfiltered");
    property p_stick;
        $fell(irq) |-> $past(reg_wr) ||
            $past(power_mode) != $past(power_mode, 2);
    endproperty
    a_stick: assert property (p_stick) else $error("irq self clear");
    property p_pull; !(pull_up_en && pull_down_en); endproperty
    a_pull: assert property (p_pull) else $error("both biases");
endmodule : hvw_wake_monitor

bind hvw_wake hvw_wake_monitor u_mon (.clock(clock), .sys_rst(sys_rst),
    .hv_wake_pin(hv_wake_pin),
    .fail_out_multipurpose_pin(fail_out_multipurpose_pin),
    .cyclic_on_window(cyclic_on_window), .power_mode(power_mode),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .wake_request(wake_request),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

// file: tb/hvw_pin_model.sv
// External switch driving the wake pin
`timescale 1ns/10ps
module hvw_pin_model (
    input wire logic clock,
    output logic pin
);
    initial pin = 1'b0;
    // Moves just after an edge, then rests n cycles
    task automatic hold(input logic v, input int n);
        @(posedge clock);
        pin <= v;
        repeat (n) @(posedge clock);
    endtask : hold
endmodule : hvw_pin_model

// file: tb/test_hvw_wake.sv
// Self-checking bench of the wake block
`timescale 1ns/10ps
`include "hvw_regs.svh"
module test_hvw_wake;
    import hvw_pkg::*;
    localparam logic [3:0] ctl = `HVW_OFF_CTRL;
    localparam logic [3:0] evt = `HVW_OFF_EVT;
    localparam logic [3:0] lvl = `HVW_OFF_LVL;
    localparam logic [3:0] msk = `HVW_OFF_MASK;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic pin;
    logic alt_pin = 1'b0;
    logic win = 1'b0;
    hvw_pmode_t power_mode = HVW_PM_NORMAL;
    logic init_mode = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq, wake_request, pull_up_en, pull_down_en;
    int failures = 0;
    int checks = 0;
    int wakes = 0;
    int cyc = 0;
    always #4 clock = ~clock;
    hvw_pin_model pm (.clock(clock), .pin(pin));
    hvw_wake dut (.clock(clock), .sys_rst(sys_rst), .hv_wake_pin(pin),
        .fail_out_multipurpose_pin(alt_pin), .cyclic_on_window(win),
        .power_mode(power_mode), .init_mode(init_mode),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .wake_request(wake_request), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en));
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic chk1(input string s, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %b seen %b", s, e, g);
        end
    endtask : chk1
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        // Data stand for this cycle; taken at its closing edge
        @(posedge clock);
        chk("reg_rdata", e, reg_rdata);
    endtask : rd
    task automatic window;
        @(posedge clock);
        win <= 1'b1;
        repeat (4) @(posedge clock);
        win <= 1'b0;
        repeat (6) @(posedge clock);
    endtask : window
    // Tests need about 15400 cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (wake_request === 1'b1) wakes <= wakes + 1;
        if (cyc == 30000) begin
            failures = failures + 1;
            close_out();
        end
    end
    initial begin
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
        wr(ctl, 8'h01);
        pm.hold(1'b1, 2020);
        chk1("irq", 1'b1, irq);
        rd(evt, 8'h01);
        rd(lvl, 8'h01);
        wr(msk, 8'h01);
        rd(msk, 8'h01);
        chk1("irq", 1'b0, irq);
        wr(msk, 8'h00);
        wr(evt, 8'h00);
        pm.hold(1'b0, 5);
        pm.hold(1'b1, 2020);
        rd(evt, 8'h01);
        wr(evt, 8'h01);
        rd(evt, 8'h00);
        chk1("irq", 1'b0, irq);
        pm.hold(1'b0, 1000);
        pm.hold(1'b1, 2020);
        rd(evt, 8'h00);
        pm.hold(1'b0, 2020);
        rd(evt, 8'h01);
        wr(evt, 8'h01);
        wr(ctl, 8'h00);
        pm.hold(1'b1, 2020);
        rd(evt, 8'h00);
        power_mode <= HVW_PM_SLEEP;
        wr(ctl, 8'h01);
        rd(lvl, 8'h00);
        init_mode <= 1'b1;
        rd(lvl, 8'h01);
        rd(`HVW_OFF_MODE, 8'h06);
        init_mode <= 1'b0;
        wakes = 0;
        pm.hold(1'b0, 2020);
        chk("wake_request", 8'h01, wakes[7:0]);
        chk1("irq", 1'b0, irq);
        rd(evt, 8'h01);
        power_mode <= HVW_PM_STOP;
        repeat (3) @(posedge clock);
        chk1("irq", 1'b1, irq);
        wr(evt, 8'h01);
        wr(ctl, 8'h03);
        window();
        rd(lvl, 8'h00);
        pm.hold(1'b1, 10);
        rd(lvl, 8'h00);
        rd(evt, 8'h00);
        window();
        rd(evt, 8'h01);
        rd(lvl, 8'h01);
        wr(evt, 8'h01);
        wr(ctl, 8'h04);
        alt_pin <= 1'b1;
        repeat (2020) @(posedge clock);
        rd(`HVW_OFF_ALT, 8'h01);
        rd(evt, 8'h00);
        chk1("irq", 1'b1, irq);
        wr(msk, 8'h02);
        rd(lvl, 8'h03);
        chk1("irq", 1'b0, irq);
        for (int p = 0; p < 4; p++) begin
            wr(`HVW_OFF_PULL, p[7:0]);
            rd(`HVW_OFF_PULL, p[7:0]);
            chk1("pull_up_en", p >= 2, pull_up_en);
            chk1("pull_down_en", p == 1, pull_down_en);
        end
        close_out();
    end
endmodule : test_hvw_wake
